// file: dv/reg_file_model.sv
`timescale 1ns/1ns
// register file behind the decoder: combinational read, fixed contents
module reg_file_model (
  input wire logic [3:0] base_reg_i,
  input wire logic [3:0] index_reg_i,
  output logic [31:0] base_data_o,
  output logic [31:0] index_data_o
);
  logic [31:0] regs [16];

  // register n holds n in every nibble; the all-ones top one forces address wrap
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 32'h1111_1111 * 32'(i);
    end
  end

  // same-cycle answer, the decoder samples it one cycle after the request
  assign base_data_o = regs[base_reg_i];
  assign index_data_o = regs[index_reg_i];
endmodule

// file: dv/test_instr_format_and_ea_decoder.sv
`timescale 1ns/1ns
module test_instr_format_and_ea_decoder;
  typedef struct packed {
    logic v;
    logic [63:0] ins;
    logic [2:0] f;
    logic [31:0] pc;
  } req_t;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [63:0] instr_i = 64'h0;
  instr_dec_pkg::fmt_t fmt_i = instr_dec_pkg::FMT_REGISTER;
  logic [31:0] pc_i = 32'h0;
  logic [31:0] base_data_i, index_data_i, operand_const_o, eff_addr_o;
  logic [3:0] base_reg_o, index_reg_o, first_register_field_o, second_register_field_o;
  logic dec_valid_o, const_valid_o, ea_valid_o, to_macro_store_o, macro_priv_o, bad_mode_o;
  logic [7:0] opcode_o;
  instr_dec_pkg::mode_t mode_o;
  logic [2:0] length_o;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] lfsr = 32'h0001_3083;
  req_t d1 = '0;
  req_t d2 = '0;

  instr_format_and_ea_decoder dut (
    .core_clk_i, .resetn_i, .instr_valid_i, .instr_i, .fmt_i, .pc_i, .base_data_i,
    .index_data_i, .base_reg_o, .index_reg_o, .dec_valid_o, .opcode_o,
    .first_register_field_o, .second_register_field_o, .operand_const_o, .const_valid_o,
    .eff_addr_o, .ea_valid_o, .mode_o, .length_o, .to_macro_store_o, .macro_priv_o,
    .bad_mode_o
  );

  reg_file_model rf (
    .base_reg_i(base_reg_o),
    .index_reg_i(index_reg_o),
    .base_data_o(base_data_i),
    .index_data_o(index_data_i)
  );

  // 100 ns clock
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  // 32 steps per draw so successive words are not mere shifts of each other
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end
    return lfsr;
  endfunction

  // contents the register file model holds for register n
  function automatic logic [31:0] rv(input logic [3:0] n);
    return {8{n}};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reference decode of one taken request against the outputs now showing
  task automatic compare(input req_t q);
    logic [15:0] p0;
    logic [31:0] k, ea, len, b, x, s16;
    logic known, cv;
    instr_dec_pkg::mode_t md;
    p0 = q.ins[15:0];
    b = rv(p0[3:0]);
    x = rv(q.ins[23:20]);
    s16 = {{16{q.ins[31]}}, q.ins[31:16]};
    k = 32'h0;
    ea = 32'h0;
    len = 32'h1;
    known = 1'b1;
    cv = 1'b1;
    md = instr_dec_pkg::MODE_NONE;
    check(32'(opcode_o), 32'(p0[15:8]), "opcode");
    case (q.f)
      instr_dec_pkg::FMT_REGISTER: begin
        cv = 1'b0;
        check(32'(first_register_field_o), 32'(p0[7:4]), "first field");
        check(32'(second_register_field_o), 32'(p0[3:0]), "second field");
      end
      instr_dec_pkg::FMT_QUICK: k = {28'h0, p0[7:4]};
      instr_dec_pkg::FMT_IMMEDIATE: begin
        len = (p0[7:4] == instr_dec_pkg::IMM32_SEL) ? 32'h3 : 32'h2;
        k = (len == 32'h3) ? q.ins[47:16] : s16;
        check(32'(bad_mode_o), 32'((p0[7:4] != 4'h3) && (p0[7:4] != 4'hb)), "imm sel");
      end
      instr_dec_pkg::FMT_CONTROL: k = {24'h0, p0[7:0]};
      instr_dec_pkg::FMT_MACRO: begin
        len = 32'h2;
        // macro code travels as a small constant, registers sit in parcel two
        k = 32'(p0[6:0]);
        check(32'(macro_priv_o), 32'(p0[9]), "privilege");
        check(32'(first_register_field_o), 32'(q.ins[23:20]), "macro first");
        check(32'(second_register_field_o), 32'(q.ins[19:16]), "macro second");
      end
      default: begin
        cv = 1'b0;
        if (!p0[8]) begin
          md = instr_dec_pkg::MODE_REL;
          ea = rv(p0[7:4]);
          check(32'(first_register_field_o), 32'(p0[7:4]), "mem first field");
        end else begin
          len = 32'h2;
          case (p0[7:4])
            instr_dec_pkg::AM_REL12: begin
              md = instr_dec_pkg::MODE_REL12;
              ea = b + {{20{q.ins[31]}}, q.ins[31:20]};
            end
            instr_dec_pkg::AM_REL32: begin
              md = instr_dec_pkg::MODE_REL32;
              ea = b + q.ins[63:32];
              len = 32'h4;
            end
            instr_dec_pkg::AM_PC16_ABS16: begin
              md = p0[3] ? instr_dec_pkg::MODE_ABS16 : instr_dec_pkg::MODE_PC16;
              ea = p0[3] ? s16 : q.pc + s16;
            end
            instr_dec_pkg::AM_PC32_ABS32: begin
              md = p0[3] ? instr_dec_pkg::MODE_ABS32 : instr_dec_pkg::MODE_PC32;
              ea = p0[3] ? q.ins[47:16] : q.pc + q.ins[47:16];
              len = 32'h3;
            end
            instr_dec_pkg::AM_PC_INDEXED: begin
              md = instr_dec_pkg::MODE_PC_INDEXED;
              ea = q.pc + x;
              known = (q.ins[31:24] == 8'h00);
            end
            instr_dec_pkg::AM_REL_INDEXED: begin
              md = instr_dec_pkg::MODE_REL_INDEXED;
              ea = b + x;
              known = (q.ins[31:24] == 8'h00);
              check(32'(bad_mode_o), 32'(!known), "index zero bits");
            end
            default: begin
              len = 32'h1;
              known = 1'b0;
              check(32'(bad_mode_o), 32'h1, "bad selector");
              check(32'(mode_o), 32'(instr_dec_pkg::MODE_NONE), "none mode");
            end
          endcase
        end
      end
    endcase
    check(32'(length_o), len, "length");
    check(32'(to_macro_store_o), 32'(q.f == instr_dec_pkg::FMT_MACRO), "macro route");
    check(32'(const_valid_o), 32'(cv), "const valid");
    if (cv) check(operand_const_o, k, "constant");
    if (q.f != instr_dec_pkg::FMT_MEMORY) begin
      check(32'(ea_valid_o), 32'h0, "ea valid off");
    end else if (known) begin
      check(32'(ea_valid_o), 32'h1, "ea valid");
      check(32'(mode_o), 32'(md), "mode");
      check(eff_addr_o, ea, "address");
    end
  endtask

  // inputs settle at the falling edge; a request seen here answers two edges later
  always @(negedge core_clk_i) begin
    if (!resetn_i) begin
      d1 = '0;
      d2 = '0;
      check(32'(dec_valid_o), 32'h0, "valid in reset");
      check(eff_addr_o, 32'h0, "address in reset");
    end else begin
      check(32'(dec_valid_o), 32'(d2.v), "result pulse");
      if (d2.v) compare(d2);
      d2 = d1;
      d1 = {instr_valid_i, instr_i, fmt_i, pc_i};
    end
  end

  // random stream with gaps and back-to-back runs; boundary fields forced now and then
  task automatic run(input int n);
    logic [63:0] ins;
    logic [31:0] r;
    for (int c = 0; c < n; c++) begin
      @(posedge core_clk_i);
      ins = {rnd(), rnd()};
      r = rnd();
      if (r[1:0] == 2'h0) ins[31:16] = 16'h8000;
      if (r[2]) ins[31:24] = 8'h00;
      instr_valid_i <= (r[5:3] != 3'h0);
      instr_i <= ins;
      fmt_i <= instr_dec_pkg::fmt_t'(3'(r[31:8] % 6));
      pc_i <= rnd();
    end
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    run(1500);
    // drain, then a second reset in mid run; let the last request's edge pass first
    @(posedge core_clk_i);
    instr_valid_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    run(1500);
    @(posedge core_clk_i);
    instr_valid_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    report_and_stop();
  end

  // about 3000 cycles expected; a hang is cut at 5000
  initial begin
    #(100 * 5000);
    fail_count++;
    report_and_stop();
  end
endmodule

// file: pkg/instr_dec_pkg.sv
package instr_dec_pkg;

  // parcel geometry
  localparam int PARCEL_W = 16;
  localparam int INSTR_W = 64;
  localparam int WORD_W = 32;

  // instruction lengths in parcels
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR = 3'h4;

  // field positions inside the first parcel
  localparam int OPC_LSB = 8;
  localparam int PRIV_BIT = 9;
  localparam int MEM_SEL_BIT = 8;
  localparam int FIELD1_LSB = 4;
  localparam int FIELD2_LSB = 0;
  localparam int ABS_SEL_BIT = 3;

  // field positions inside the whole instruction
  localparam int DISP12_LSB = 20;
  localparam int INDEX_LSB = 20;
  localparam int EXT_R2_LSB = 16;
  localparam int P1_LSB = 16;
  localparam int P2_LSB = 32;

  // address mode selector codes, bits 7:4 of the first parcel
  localparam logic [3:0] AM_REL12 = 4'ha;
  localparam logic [3:0] AM_REL32 = 4'hb;
  localparam logic [3:0] AM_PC16_ABS16 = 4'hd;
  localparam logic [3:0] AM_PC32_ABS32 = 4'h9;
  localparam logic [3:0] AM_PC_INDEXED = 4'hc;
  localparam logic [3:0] AM_REL_INDEXED = 4'he;

  // immediate size selector codes in bits 7:4
  localparam logic [3:0] IMM16_SEL = 4'hb;
  localparam logic [3:0] IMM32_SEL = 4'h3;

  // reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] REG_RESET = 4'h0;

  // format class, given by the opcode table upstream
  typedef enum logic [2:0] {
    FMT_REGISTER,
    FMT_QUICK,
    FMT_IMMEDIATE,
    FMT_CONTROL,
    FMT_MACRO,
    FMT_MEMORY
  } fmt_t;

  // effective address modes
  typedef enum logic [3:0] {
    MODE_NONE,
    MODE_REL,
    MODE_REL12,
    MODE_REL32,
    MODE_ABS16,
    MODE_ABS32,
    MODE_PC16,
    MODE_PC32,
    MODE_REL_INDEXED,
    MODE_PC_INDEXED
  } mode_t;

endpackage

// file: src/ea_adder.sv
`timescale 1ns/1ns
// forms the effective address from the chosen base and offset
module ea_adder (
  input wire instr_dec_pkg::mode_t mode_i,
  input wire logic [31:0] base_i,
  input wire logic [31:0] index_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] disp_i,
  output logic [31:0] ea_o
);

  logic [31:0] lhs;
  logic [31:0] rhs;

  // carry out of bit 31 simply falls off, no flag is kept
  always_comb begin
    lhs = 32'h0000_0000;
    rhs = 32'h0000_0000;
    case (mode_i)
      instr_dec_pkg::MODE_REL: begin
        lhs = base_i;
      end
      instr_dec_pkg::MODE_REL12, instr_dec_pkg::MODE_REL32: begin
        lhs = base_i;
        rhs = disp_i;
      end
      instr_dec_pkg::MODE_ABS16, instr_dec_pkg::MODE_ABS32: begin
        rhs = disp_i;
      end
      instr_dec_pkg::MODE_PC16, instr_dec_pkg::MODE_PC32: begin
        lhs = pc_i;
        rhs = disp_i;
      end
      instr_dec_pkg::MODE_REL_INDEXED: begin
        lhs = base_i;
        rhs = index_i;
      end
      instr_dec_pkg::MODE_PC_INDEXED: begin
        lhs = pc_i;
        rhs = index_i;
      end
      default: begin
        lhs = 32'h0000_0000;
      end
    endcase
    ea_o = lhs + rhs;
  end

endmodule

// file: src/instr_format_and_ea_decoder.sv
`timescale 1ns/1ns
// Summary of operation
// - length of one to four parcels from first
// - register format: opcode, two register fields
// - quick constant zero extended from bits 7:4
// - 16-bit immediate sign extended from parcel two
// - 32-bit immediate assembled, low half first
// - control byte from bits 7:0
// - macro goes to macro store, bit 9 privileged
// - address mode from bit 8 then selector
// - displacements and absolutes sign extended to 32
// - relative: address is first register contents
// - relative plus sign extended 12-bit displacement
// - relative plus signed 32-bit displacement
// - 16-bit absolute, sign extended field
// - 32-bit absolute used directly
// - program counter plus 16-bit displacement
// - program counter plus 32-bit displacement
// - program counter is first parcel address
// - base plus index register contents
// - program counter plus index register contents
module instr_format_and_ea_decoder (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [63:0] instr_i,
  input wire instr_dec_pkg::fmt_t fmt_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] base_data_i,
  input wire logic [31:0] index_data_i,
  output logic [3:0] base_reg_o,
  output logic [3:0] index_reg_o,
  output logic dec_valid_o,
  output logic [7:0] opcode_o,
  output logic [3:0] first_register_field_o,
  output logic [3:0] second_register_field_o,
  output logic [31:0] operand_const_o,
  output logic const_valid_o,
  output logic [31:0] eff_addr_o,
  output logic ea_valid_o,
  output instr_dec_pkg::mode_t mode_o,
  output logic [2:0] length_o,
  output logic to_macro_store_o,
  output logic macro_priv_o,
  output logic bad_mode_o
);

  typedef struct packed {
    // stage one: fields taken from the parcels
    logic s1_valid;
    instr_dec_pkg::mode_t s1_mode;
    logic [7:0] s1_opcode;
    logic [3:0] s1_r1;
    logic [3:0] s1_r2;
    logic [3:0] s1_rx;
    logic [31:0] s1_const;
    logic s1_const_valid;
    logic [31:0] s1_disp;
    logic [31:0] s1_pc;
    logic [2:0] s1_len;
    logic s1_macro;
    logic s1_priv;
    logic s1_bad;
    // stage two: presented results
    logic out_valid;
    logic [7:0] out_opcode;
    logic [3:0] out_r1;
    logic [3:0] out_r2;
    logic [31:0] out_const;
    logic out_const_valid;
    logic [31:0] out_ea;
    logic out_ea_valid;
    instr_dec_pkg::mode_t out_mode;
    logic [2:0] out_len;
    logic out_macro;
    logic out_priv;
    logic out_bad;
  } state_t;

  state_t st;
  state_t next_st;

  logic [31:0] quick_val;
  logic [31:0] disp12_val;
  logic [31:0] half_p1_val;
  logic [31:0] word_p1_val;
  logic [31:0] word_p2_val;
  logic [31:0] byte_val;
  logic [31:0] ea_sum;
  logic [15:0] p0;

  assign p0 = instr_i[15:0];

  // constant extraction from the raw parcels
  parcel_fields u_fields (
    .instr_i(instr_i),
    .quick_o(quick_val),
    .disp12_o(disp12_val),
    .half_p1_o(half_p1_val),
    .word_p1_o(word_p1_val),
    .word_p2_o(word_p2_val),
    .byte_o(byte_val)
  );

  // address formation works on stage-one fields and register data
  ea_adder u_adder (
    .mode_i(st.s1_mode),
    .base_i(base_data_i),
    .index_i(index_data_i),
    .pc_i(st.s1_pc),
    .disp_i(st.s1_disp),
    .ea_o(ea_sum)
  );

  // memory mode decode, used for both mode and length
  function automatic instr_dec_pkg::mode_t mem_mode(input logic [15:0] parcel);
    instr_dec_pkg::mode_t m;
    m = instr_dec_pkg::MODE_NONE;
    if (!parcel[instr_dec_pkg::MEM_SEL_BIT]) begin
      m = instr_dec_pkg::MODE_REL;
    end else begin
      case (parcel[7:4])
        instr_dec_pkg::AM_REL12: m = instr_dec_pkg::MODE_REL12;
        instr_dec_pkg::AM_REL32: m = instr_dec_pkg::MODE_REL32;
        instr_dec_pkg::AM_PC16_ABS16: begin
          m = parcel[instr_dec_pkg::ABS_SEL_BIT] ? instr_dec_pkg::MODE_ABS16
                                                 : instr_dec_pkg::MODE_PC16;
        end
        instr_dec_pkg::AM_PC32_ABS32: begin
          m = parcel[instr_dec_pkg::ABS_SEL_BIT] ? instr_dec_pkg::MODE_ABS32
                                                 : instr_dec_pkg::MODE_PC32;
        end
        instr_dec_pkg::AM_PC_INDEXED: m = instr_dec_pkg::MODE_PC_INDEXED;
        instr_dec_pkg::AM_REL_INDEXED: m = instr_dec_pkg::MODE_REL_INDEXED;
        default: m = instr_dec_pkg::MODE_NONE;
      endcase
    end
    return m;
  endfunction

  // parcel count for each memory mode
  function automatic logic [2:0] mode_len(input instr_dec_pkg::mode_t m);
    logic [2:0] n;
    n = instr_dec_pkg::LEN_TWO;
    case (m)
      instr_dec_pkg::MODE_REL, instr_dec_pkg::MODE_NONE: n = instr_dec_pkg::LEN_ONE;
      instr_dec_pkg::MODE_REL32: n = instr_dec_pkg::LEN_FOUR;
      instr_dec_pkg::MODE_ABS32, instr_dec_pkg::MODE_PC32: n = instr_dec_pkg::LEN_THREE;
      default: n = instr_dec_pkg::LEN_TWO;
    endcase
    return n;
  endfunction

  instr_dec_pkg::mode_t cur_mode;

  assign cur_mode = mem_mode(p0);

  // next state: stage one decodes, stage two presents
  always_comb begin
    next_st = st;
    // stage one defaults for an idle cycle
    next_st.s1_valid = instr_valid_i;
    next_st.s1_mode = instr_dec_pkg::MODE_NONE;
    next_st.s1_opcode = p0[15:8];
    next_st.s1_r1 = p0[7:4];
    next_st.s1_r2 = p0[3:0];
    next_st.s1_rx = instr_dec_pkg::REG_RESET;
    next_st.s1_const = instr_dec_pkg::WORD_RESET;
    next_st.s1_const_valid = 1'b0;
    next_st.s1_disp = instr_dec_pkg::WORD_RESET;
    next_st.s1_pc = pc_i;
    next_st.s1_len = instr_dec_pkg::LEN_ONE;
    next_st.s1_macro = 1'b0;
    next_st.s1_priv = 1'b0;
    next_st.s1_bad = 1'b0;
    case (fmt_i)
      instr_dec_pkg::FMT_REGISTER: begin
        next_st.s1_len = instr_dec_pkg::LEN_ONE;
      end
      instr_dec_pkg::FMT_QUICK: begin
        next_st.s1_const = quick_val;
        next_st.s1_const_valid = 1'b1;
        next_st.s1_r1 = instr_dec_pkg::REG_RESET;
      end
      instr_dec_pkg::FMT_IMMEDIATE: begin
        next_st.s1_r1 = instr_dec_pkg::REG_RESET;
        next_st.s1_const_valid = 1'b1;
        if (p0[7:4] == instr_dec_pkg::IMM32_SEL) begin
          next_st.s1_const = word_p1_val;
          next_st.s1_len = instr_dec_pkg::LEN_THREE;
        end else begin
          next_st.s1_const = half_p1_val;
          next_st.s1_len = instr_dec_pkg::LEN_TWO;
          next_st.s1_bad = (p0[7:4] != instr_dec_pkg::IMM16_SEL);
        end
      end
      instr_dec_pkg::FMT_CONTROL: begin
        next_st.s1_const = byte_val;
        next_st.s1_const_valid = 1'b1;
        next_st.s1_r1 = instr_dec_pkg::REG_RESET;
        next_st.s1_r2 = instr_dec_pkg::REG_RESET;
      end
      instr_dec_pkg::FMT_MACRO: begin
        // register fields of a macro live in the second parcel
        next_st.s1_macro = 1'b1;
        next_st.s1_priv = p0[instr_dec_pkg::PRIV_BIT];
        next_st.s1_const = {25'h0, p0[6:0]};
        next_st.s1_const_valid = 1'b1;
        next_st.s1_r1 = instr_i[23:20];
        next_st.s1_r2 = instr_i[19:16];
        next_st.s1_len = instr_dec_pkg::LEN_TWO;
      end
      instr_dec_pkg::FMT_MEMORY: begin
        next_st.s1_mode = cur_mode;
        next_st.s1_len = mode_len(cur_mode);
        next_st.s1_bad = (cur_mode == instr_dec_pkg::MODE_NONE);
        case (cur_mode)
          instr_dec_pkg::MODE_REL: begin
            next_st.s1_r1 = p0[7:4];
          end
          instr_dec_pkg::MODE_REL12: begin
            next_st.s1_r1 = p0[3:0];
            next_st.s1_r2 = instr_i[19:16];
            next_st.s1_disp = disp12_val;
          end
          instr_dec_pkg::MODE_REL32: begin
            next_st.s1_r1 = p0[3:0];
            next_st.s1_r2 = instr_i[19:16];
            next_st.s1_disp = word_p2_val;
          end
          instr_dec_pkg::MODE_ABS16, instr_dec_pkg::MODE_PC16: begin
            next_st.s1_r1 = instr_dec_pkg::REG_RESET;
            next_st.s1_r2 = {1'b0, p0[2:0]};
            next_st.s1_disp = half_p1_val;
          end
          instr_dec_pkg::MODE_ABS32, instr_dec_pkg::MODE_PC32: begin
            next_st.s1_r1 = instr_dec_pkg::REG_RESET;
            next_st.s1_r2 = {1'b0, p0[2:0]};
            next_st.s1_disp = word_p1_val;
          end
          instr_dec_pkg::MODE_REL_INDEXED: begin
            next_st.s1_r1 = p0[3:0];
            next_st.s1_rx = instr_i[23:20];
            next_st.s1_r2 = instr_i[19:16];
            next_st.s1_bad = (instr_i[31:24] != 8'h00);
          end
          instr_dec_pkg::MODE_PC_INDEXED: begin
            next_st.s1_r1 = instr_dec_pkg::REG_RESET;
            next_st.s1_rx = instr_i[23:20];
            next_st.s1_r2 = instr_i[19:16];
            next_st.s1_bad = (instr_i[31:24] != 8'h00);
          end
          default: begin
            next_st.s1_r1 = instr_dec_pkg::REG_RESET;
          end
        endcase
      end
      default: begin
        next_st.s1_bad = 1'b1;
      end
    endcase
    // stage two: register data arrives for the stage-one numbers
    next_st.out_valid = st.s1_valid;
    next_st.out_opcode = st.s1_opcode;
    next_st.out_r1 = st.s1_r1;
    next_st.out_r2 = st.s1_r2;
    next_st.out_const = st.s1_const;
    next_st.out_const_valid = st.s1_valid & st.s1_const_valid;
    next_st.out_ea = ea_sum;
    next_st.out_ea_valid = st.s1_valid & (st.s1_mode != instr_dec_pkg::MODE_NONE);
    next_st.out_mode = st.s1_mode;
    next_st.out_len = st.s1_len;
    next_st.out_macro = st.s1_valid & st.s1_macro;
    next_st.out_priv = st.s1_valid & st.s1_priv;
    next_st.out_bad = st.s1_valid & st.s1_bad;
  end

  // single state register, cleared to idle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign base_reg_o = st.s1_r1;
  assign index_reg_o = st.s1_rx;
  assign dec_valid_o = st.out_valid;
  assign opcode_o = st.out_opcode;
  assign first_register_field_o = st.out_r1;
  assign second_register_field_o = st.out_r2;
  assign operand_const_o = st.out_const;
  assign const_valid_o = st.out_const_valid;
  assign eff_addr_o = st.out_ea;
  assign ea_valid_o = st.out_ea_valid;
  assign mode_o = st.out_mode;
  assign length_o = st.out_len;
  assign to_macro_store_o = st.out_macro;
  assign macro_priv_o = st.out_priv;
  assign bad_mode_o = st.out_bad;

  // a decoded instruction shows up exactly two edges later
  AST_VALID_LATENCY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i |-> ##2 dec_valid_o)
    else $error("decode result not presented two cycles after request");

  AST_LEN_RANGE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    dec_valid_o |-> (length_o >= 3'h1) && (length_o <= 3'h4))
    else $error("instruction length outside one to four parcels");

  AST_QUICK_ZERO: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && fmt_i == instr_dec_pkg::FMT_QUICK)
      |-> ##2 operand_const_o == {28'h0000000, $past(instr_i[7:4], 2)})
    else $error("quick constant not zero extended");

  AST_CTRL_BYTE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && fmt_i == instr_dec_pkg::FMT_CONTROL)
      |-> ##2 operand_const_o[31:8] == 24'h000000 && operand_const_o[7:0] == $past(instr_i[7:0], 2))
    else $error("control byte not passed through");

  AST_MACRO_PRIV: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && fmt_i == instr_dec_pkg::FMT_MACRO)
      |-> ##2 to_macro_store_o && (macro_priv_o == $past(instr_i[9], 2)))
    else $error("macro routing or privilege bit wrong");

  AST_REL_BASE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (ea_valid_o && mode_o == instr_dec_pkg::MODE_REL) |-> eff_addr_o == $past(base_data_i))
    else $error("relative address is not the base register");

  AST_ABS16_TOP: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (ea_valid_o && mode_o == instr_dec_pkg::MODE_ABS16 && eff_addr_o[15])
      |-> eff_addr_o[31:16] == 16'hffff)
    else $error("negative 16-bit absolute not in top region");

  AST_PC_FIRST_PARCEL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (ea_valid_o && mode_o == instr_dec_pkg::MODE_PC_INDEXED)
      |-> eff_addr_o == $past(pc_i, 2) + $past(index_data_i))
    else $error("pc indexed address does not use instruction pc");

  AST_REL12_SUM: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (ea_valid_o && mode_o == instr_dec_pkg::MODE_REL12)
      |-> eff_addr_o == $past(base_data_i) + {{20{$past(instr_i[31], 2)}}, $past(instr_i[31:20], 2)})
    else $error("relative 12-bit address wrong");

endmodule

// file: src/parcel_fields.sv
`timescale 1ns/1ns
// pulls the extended constants out of the raw parcels
module parcel_fields (
  input wire logic [63:0] instr_i,
  output logic [31:0] quick_o,
  output logic [31:0] disp12_o,
  output logic [31:0] half_p1_o,
  output logic [31:0] word_p1_o,
  output logic [31:0] word_p2_o,
  output logic [31:0] byte_o
);

  // quick is zero filled, everything signed is sign filled
  always_comb begin
    quick_o = {28'h0000000, instr_i[7:4]};
    disp12_o = {{20{instr_i[31]}}, instr_i[31:20]};
    half_p1_o = {{16{instr_i[31]}}, instr_i[31:16]};
    word_p1_o = instr_i[47:16];
    word_p2_o = instr_i[63:32];
    byte_o = {24'h000000, instr_i[7:0]};
  end

endmodule
